// ---- bss_top.sv ----
// What this block does
// - spi data and clock pins are start-up straps
// - spi activity never alters latched strap values
// - low reset pin resets all but the backup copy; input only
// - antenna detect low means antenna present
// - three boot straps effective right after start-up
// - undriven strap reads one via pull-up
// - message config overrides straps; backup copy persists
// - sample straps first, then release shared pins
// - transmit-pending active while output data queued
// - transmit-pending polarity and byte threshold configurable
// - transmit-pending on gpio 05, off after reset
// - antenna power-off on gpio 22, off by default
// - sensor variant: spi master, two chip selects
// - direction high is forward; odometer gives speed pulses
// - detect serial flash at start-up, needs 1 Mbit
// - timing variant antenna signals on gpio 13,17,8
// - timing variant default leaves antenna supply off
// - event input: time mark or power-save wake-up
`include "bss_map.svh"
`default_nettype none

module bss_top
  import bss_pkg::*;
(
  input  wire logic                         i_clk,
  input  wire logic                         i_srst,
  // reset pin, input only
  input  wire logic                         i_reset_n,
  output logic                              o_sys_reset,
  // boot straps and whether anything drives them
  input  wire logic                         i_boot_strap_port_sel0,
  input  wire logic                         i_boot_strap_port_sel0_drv,
  input  wire logic                         i_boot_strap_port_sel1,
  input  wire logic                         i_boot_strap_port_sel1_drv,
  input  wire logic                         i_boot_strap_nav_sel0,
  input  wire logic                         i_boot_strap_nav_sel0_drv,
  input  wire logic                         i_sensor_variant,
  input  wire logic                         i_timing_variant,
  output logic                              o_startup_done,
  output logic                              o_strap_ss_fault,
  output logic                              o_cfg_port_sel0,
  output logic                              o_cfg_port_sel1,
  output logic                              o_cfg_nav_sel0,
  // configuration by message
  input  wire logic                         i_cfg_wr,
  input  wire logic [`BSS_CFG_W-1:0]        i_cfg_data,
  input  wire logic                         i_cfg_save,
  input  wire logic                         i_cfg_revert,
  input  wire logic                         i_backup_present,
  // serial flash probe
  output logic                              o_flash_probe_req,
  input  wire logic                         i_flash_probe_done,
  input  wire logic                         i_flash_detect,
  input  wire logic [`BSS_FLASH_SIZE_W-1:0] i_flash_size_kbit,
  output logic                              o_flash_present,
  // spi pins
  input  wire logic                         i_spi_mosi,
  output logic                              o_spi_mosi,
  output logic                              o_spi_mosi_oe,
  input  wire logic                         i_spi_miso,
  output logic                              o_spi_miso,
  output logic                              o_spi_miso_oe,
  input  wire logic                         i_spi_sck,
  output logic                              o_spi_sck,
  output logic                              o_spi_sck_oe,
  input  wire logic                         i_spi_ss_n,
  output logic                              o_rate_sensor_select_n,
  output logic                              o_temp_sensor_select_n,
  // spi engine side
  input  wire logic                         i_core_mosi,
  input  wire logic                         i_core_sck,
  input  wire logic                         i_core_miso,
  input  wire logic                         i_core_miso_oe,
  input  wire logic                         i_core_rate_sel_n,
  input  wire logic                         i_core_temp_sel_n,
  output logic                              o_core_mosi,
  output logic                              o_core_miso,
  output logic                              o_core_sck,
  output logic                              o_core_ss_n,
  // transmit-pending indicator
  input  wire logic                         i_txrdy_cfg_wr,
  input  wire logic                         i_txrdy_en,
  input  wire logic                         i_txrdy_active_low,
  input  wire logic [`BSS_TXQ_W-1:0]        i_txrdy_thresh,
  input  wire logic [`BSS_TXQ_W-1:0]        i_txq_bytes,
  output logic                              o_gpio05,
  output logic                              o_gpio05_oe,
  // antenna supervision
  input  wire logic                         i_antenna_present_low,
  input  wire logic                         i_ant_cfg_wr,
  input  wire logic                         i_antenna_power_off_pin_en,
  input  wire logic                         i_antenna_power_off,
  input  wire logic                         i_gpio8,
  input  wire logic                         i_gpio17,
  output logic                              o_gpio13,
  output logic                              o_gpio13_oe,
  output logic                              o_gpio22,
  output logic                              o_gpio22_oe,
  output logic                              o_antenna_present,
  output logic                              o_antenna_short_flag,
  output logic                              o_antenna_supply_on,
  // wheel sensors
  input  wire logic                         i_wheel_forward_dir,
  input  wire logic                         i_odo_speed,
  output logic                              o_wheel_forward,
  output logic                              o_speed_pulse,
  // external event
  input  wire logic                         i_ext_event_in,
  input  wire logic                         i_event_wake_mode,
  input  wire logic                         i_power_save,
  output logic                              o_time_mark,
  output logic                              o_wake_req
);

  logic [`BSS_SYNC_W-1:0] sync_in;
  logic [`BSS_SYNC_W-1:0] sync_out;

  bss_sync #(
    .WIDTH   (`BSS_SYNC_W),
    .RST_VAL (`BSS_SYNC_RST)
  ) u_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (sync_in),
    .o_sync  (sync_out)
  );

  assign sync_in = {i_ext_event_in, i_odo_speed, i_wheel_forward_dir, i_gpio17,
                    i_gpio8, i_antenna_present_low, i_reset_n};

  // the pin only listens; nothing here drives a reset outward
  wire core_rst = i_srst | ~sync_out[`BSS_SY_RESET_N];
  assign o_sys_reset = core_rst;

  bss_state_type          state_reg;
  bss_state_type          state_next;
  logic [`BSS_CNT_W-1:0]  cnt_reg;
  logic [`BSS_CFG_W-1:0]  strap_reg;
  logic [`BSS_CFG_W-1:0]  cfg_reg;
  logic [`BSS_CFG_W-1:0]  bbr_cfg_reg;
  logic                   bbr_valid_reg;
  logic                   sensor_reg;
  logic                   timing_reg;
  logic                   ss_fault_reg;
  logic                   flash_reg;

  // undriven strap pins float up to one
  wire [`BSS_CFG_W-1:0] strap_level = {
    i_boot_strap_nav_sel0_drv  ? i_boot_strap_nav_sel0  : 1'b1,
    i_boot_strap_port_sel1_drv ? i_boot_strap_port_sel1 : 1'b1,
    i_boot_strap_port_sel0_drv ? i_boot_strap_port_sel0 : 1'b1
  };

  wire settle_end  = (state_reg == ST_SAMPLE) && (cnt_reg == `BSS_SETTLE_LAST);
  wire probe_tmo   = (cnt_reg == `BSS_PROBE_LAST);
  wire probe_end   = (state_reg == ST_PROBE) && (i_flash_probe_done || probe_tmo);
  wire run         = (state_reg == ST_RUN);
  wire flash_big   = (i_flash_size_kbit >= `BSS_FLASH_MIN_KBIT);
  wire [`BSS_CFG_W-1:0] boot_cfg = bbr_valid_reg ? bbr_cfg_reg : strap_level;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET:  state_next = ST_SAMPLE;
      ST_SAMPLE: if (settle_end) begin
        state_next = ST_PROBE;
      end
      ST_PROBE:  if (probe_end) begin
        state_next = ST_RUN;
      end
      ST_RUN:    state_next = ST_RUN;
      default:   state_next = ST_RESET;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      state_reg <= ST_RESET;
      cnt_reg   <= `BSS_CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= (state_next != state_reg) ? `BSS_CNT_ZERO : cnt_reg + `BSS_CNT_ONE;
    end
  end

  // straps are caught once, at the end of the settle time, and never again
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      strap_reg    <= `BSS_CFG_DEFAULT;
      sensor_reg   <= 1'b0;
      timing_reg   <= 1'b0;
      ss_fault_reg <= 1'b0;
    end else if (settle_end) begin
      strap_reg    <= strap_level;
      sensor_reg   <= i_sensor_variant;
      timing_reg   <= i_timing_variant;
      ss_fault_reg <= ~i_spi_ss_n;
    end
  end

  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      flash_reg <= 1'b0;
    end else if (probe_end) begin
      flash_reg <= i_flash_probe_done & i_flash_detect & flash_big;
    end
  end

  // effective configuration: straps or backup copy, then message writes
  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      cfg_reg <= `BSS_CFG_DEFAULT;
    end else if (settle_end) begin
      cfg_reg <= boot_cfg;
    end else if (run && i_cfg_wr) begin
      cfg_reg <= i_cfg_data;
    end else if (run && i_cfg_revert) begin
      cfg_reg <= strap_reg;
    end
  end

  // backup copy lives through core reset; only loss of backup supply clears it
  always_ff @(posedge i_clk) begin
    if (!i_backup_present) begin
      bbr_valid_reg <= 1'b0;
      bbr_cfg_reg   <= `BSS_CFG_DEFAULT;
    end else if (run && i_cfg_save) begin
      bbr_valid_reg <= 1'b1;
      bbr_cfg_reg   <= cfg_reg;
    end
  end

  assign o_startup_done   = run;
  assign o_strap_ss_fault = ss_fault_reg;
  assign o_cfg_port_sel0  = cfg_reg[`BSS_CFG_PORT0];
  assign o_cfg_port_sel1  = cfg_reg[`BSS_CFG_PORT1];
  assign o_cfg_nav_sel0   = cfg_reg[`BSS_CFG_NAV0];
  assign o_flash_probe_req = (state_reg == ST_PROBE);
  assign o_flash_present  = flash_reg;

  // spi pins stay undriven until start-up is over
  wire master_run = run & sensor_reg;
  wire slave_run  = run & ~sensor_reg;

  logic mosi_reg;
  logic mosi_oe_reg;
  logic miso_reg;
  logic miso_oe_reg;
  logic sck_reg;
  logic sck_oe_reg;
  logic rate_sel_n_reg;
  logic temp_sel_n_reg;

  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      mosi_reg       <= 1'b0;
      mosi_oe_reg    <= 1'b0;
      miso_reg       <= 1'b0;
      miso_oe_reg    <= 1'b0;
      sck_reg        <= 1'b0;
      sck_oe_reg     <= 1'b0;
      rate_sel_n_reg <= 1'b1;
      temp_sel_n_reg <= 1'b1;
    end else begin
      mosi_reg       <= i_core_mosi;
      mosi_oe_reg    <= master_run;
      sck_reg        <= i_core_sck;
      sck_oe_reg     <= master_run;
      miso_reg       <= i_core_miso;
      miso_oe_reg    <= slave_run & i_core_miso_oe;
      rate_sel_n_reg <= master_run ? i_core_rate_sel_n : 1'b1;
      temp_sel_n_reg <= master_run ? i_core_temp_sel_n : 1'b1;
    end
  end

  assign o_spi_mosi    = mosi_reg;
  assign o_spi_mosi_oe = mosi_oe_reg;
  assign o_spi_miso    = miso_reg;
  assign o_spi_miso_oe = miso_oe_reg;
  assign o_spi_sck     = sck_reg;
  assign o_spi_sck_oe  = sck_oe_reg;
  assign o_rate_sensor_select_n = rate_sel_n_reg;
  assign o_temp_sensor_select_n = temp_sel_n_reg;

  // the engine sees the pins only after start-up, so strap wiggles never reach it
  assign o_core_mosi = slave_run  & i_spi_mosi;
  assign o_core_sck  = slave_run  & i_spi_sck;
  assign o_core_miso = master_run & i_spi_miso;
  assign o_core_ss_n = slave_run  ? i_spi_ss_n : 1'b1;

  // transmit-pending indicator
  logic                  txr_en_reg;
  logic                  txr_low_reg;
  logic [`BSS_TXQ_W-1:0] txr_thr_reg;
  logic                  gpio05_reg;

  wire txr_pending = (i_txq_bytes != `BSS_TXQ_EMPTY) &&
                     (i_txq_bytes >= txr_thr_reg);

  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      txr_en_reg  <= 1'b0;
      txr_low_reg <= 1'b0;
      txr_thr_reg <= `BSS_TXQ_EMPTY;
    end else if (i_txrdy_cfg_wr) begin
      txr_en_reg  <= i_txrdy_en;
      txr_low_reg <= i_txrdy_active_low;
      txr_thr_reg <= i_txrdy_thresh;
    end
  end

  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      gpio05_reg <= 1'b0;
    end else begin
      gpio05_reg <= txr_pending ^ txr_low_reg;
    end
  end

  assign o_gpio05    = gpio05_reg;
  assign o_gpio05_oe = txr_en_reg;

  // antenna supervision; supply starts off so a short cannot be powered blind
  logic antenna_power_off_en_reg;
  logic ant_off_reg;

  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      antenna_power_off_en_reg <= 1'b0;
      ant_off_reg   <= 1'b1;
    end else if (i_ant_cfg_wr) begin
      antenna_power_off_en_reg <= i_antenna_power_off_pin_en;
      ant_off_reg   <= i_antenna_power_off;
    end else if (run && i_cfg_revert && timing_reg) begin
      ant_off_reg   <= 1'b1;
    end
  end

  assign o_gpio22    = ant_off_reg;
  assign o_gpio22_oe = antenna_power_off_en_reg & ~timing_reg;
  assign o_gpio13    = ant_off_reg;
  assign o_gpio13_oe = timing_reg;
  assign o_antenna_supply_on = ~ant_off_reg;

  wire ant_low_level = timing_reg ? sync_out[`BSS_SY_GPIO8] :
                                    sync_out[`BSS_SY_ANT_LOW];
  assign o_antenna_present    = ~ant_low_level;
  assign o_antenna_short_flag = timing_reg & sync_out[`BSS_SY_GPIO17];

  // wheel sensors and event input, edges taken after the synchroniser
  logic speed_d_reg;
  logic speed_pulse_reg;
  logic fwd_reg;
  logic event_d_reg;
  logic time_mark_reg;
  logic wake_reg;

  wire speed_rise = sync_out[`BSS_SY_SPEED] & ~speed_d_reg;
  wire event_rise = sync_out[`BSS_SY_EVENT] & ~event_d_reg;

  always_ff @(posedge i_clk) begin
    if (core_rst) begin
      speed_d_reg     <= 1'b0;
      speed_pulse_reg <= 1'b0;
      fwd_reg         <= 1'b0;
      event_d_reg     <= 1'b0;
      time_mark_reg   <= 1'b0;
      wake_reg        <= 1'b0;
    end else begin
      speed_d_reg     <= sync_out[`BSS_SY_SPEED];
      speed_pulse_reg <= speed_rise;
      fwd_reg         <= sync_out[`BSS_SY_FWD];
      event_d_reg     <= sync_out[`BSS_SY_EVENT];
      time_mark_reg   <= event_rise & ~i_event_wake_mode;
      wake_reg        <= event_rise & i_event_wake_mode & i_power_save;
    end
  end

  assign o_speed_pulse   = speed_pulse_reg;
  assign o_wheel_forward = fwd_reg;
  assign o_time_mark     = time_mark_reg;
  assign o_wake_req      = wake_reg;

endmodule

`default_nettype wire

// ---- bss_map.svh ----
`ifndef BSS_MAP_SVH
`define BSS_MAP_SVH

// core clock
`define BSS_CLK_PERIOD_NS 5

// strap settle time before sampling, least time, rounds up
`define BSS_STRAP_SETTLE_NS 100
`define BSS_STRAP_SETTLE_CYC \
  ((`BSS_STRAP_SETTLE_NS + `BSS_CLK_PERIOD_NS - 1) / `BSS_CLK_PERIOD_NS)

// longest wait for the flash probe answer, rounds down
`define BSS_PROBE_WAIT_NS 2000
`define BSS_PROBE_WAIT_CYC (`BSS_PROBE_WAIT_NS / `BSS_CLK_PERIOD_NS)

// start-up counter
`define BSS_CNT_W 9
`define BSS_CNT_ZERO 9'h000
`define BSS_CNT_ONE 9'h001
`define BSS_SETTLE_LAST (`BSS_CNT_W'(`BSS_STRAP_SETTLE_CYC - 1))
`define BSS_PROBE_LAST (`BSS_CNT_W'(`BSS_PROBE_WAIT_CYC - 1))

// smallest usable serial flash
`define BSS_FLASH_SIZE_W 16
`define BSS_FLASH_MIN_KBIT 16'h0400

// transmit queue fill level
`define BSS_TXQ_W 13
`define BSS_TXQ_EMPTY 13'h0000

// boot configuration word
`define BSS_CFG_W 3
`define BSS_CFG_PORT0 0
`define BSS_CFG_PORT1 1
`define BSS_CFG_NAV0 2
`define BSS_CFG_DEFAULT 3'h7

// synchroniser lanes and their idle levels
`define BSS_SYNC_W 7
`define BSS_SY_RESET_N 0
`define BSS_SY_ANT_LOW 1
`define BSS_SY_GPIO8 2
`define BSS_SY_GPIO17 3
`define BSS_SY_FWD 4
`define BSS_SY_SPEED 5
`define BSS_SY_EVENT 6
`define BSS_SYNC_RST 7'h07

`endif

// ---- bss_pkg.sv ----
`default_nettype none

package bss_pkg;

  // gray-coded start-up sequence
  typedef enum logic [1:0] {
    ST_RESET  = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_PROBE  = 2'h3,
    ST_RUN    = 2'h2
  } bss_state_type;

endpackage

`default_nettype wire

// ---- bss_sync.sv ----
`default_nettype none

module bss_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule

`default_nettype wire

// ---- bss_top_sva.sv ----
`include "bss_map.svh"
`default_nettype none

module bss_top_sva (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_reset_n,
  input wire logic        o_sys_reset,
  input wire logic        o_startup_done,
  input wire logic        o_cfg_port_sel0,
  input wire logic        o_cfg_port_sel1,
  input wire logic        o_cfg_nav_sel0,
  input wire logic        i_cfg_wr,
  input wire logic [2:0]  i_cfg_data,
  input wire logic        i_cfg_revert,
  input wire logic        o_flash_probe_req,
  input wire logic        i_flash_probe_done,
  input wire logic        i_flash_detect,
  input wire logic [15:0] i_flash_size_kbit,
  input wire logic        o_flash_present,
  input wire logic        o_spi_mosi_oe,
  input wire logic        o_spi_miso_oe,
  input wire logic        o_spi_sck_oe,
  input wire logic        i_txrdy_cfg_wr,
  input wire logic        i_txrdy_en,
  input wire logic        i_txrdy_active_low,
  input wire logic [12:0] i_txrdy_thresh,
  input wire logic [12:0] i_txq_bytes,
  input wire logic        o_gpio05,
  input wire logic        o_gpio05_oe,
  input wire logic        i_odo_speed,
  input wire logic        o_speed_pulse
);
  logic        tx_seen_reg;
  logic        tx_en_reg;
  logic        tx_low_reg;
  logic [12:0] tx_thr_reg;
  logic [2:0]  cfg_now;

  assign cfg_now = {o_cfg_nav_sel0, o_cfg_port_sel1, o_cfg_port_sel0};

  // shadow of indicator settings, valid once loaded after reset
  always_ff @(posedge i_clk) begin
    tx_seen_reg <= !o_sys_reset && (tx_seen_reg || i_txrdy_cfg_wr);
    if (i_txrdy_cfg_wr) begin
      tx_en_reg  <= i_txrdy_en;
      tx_low_reg <= i_txrdy_active_low;
      tx_thr_reg <= i_txrdy_thresh;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (o_sys_reset);

  property p_pin_reset;
    disable iff (i_srst) (!i_reset_n) [*3] |-> o_sys_reset;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not seen");

  property p_spi_idle;
    !o_startup_done |-> !(o_spi_mosi_oe || o_spi_miso_oe || o_spi_sck_oe);
  endproperty
  a_spi_idle: assert property (p_spi_idle) else $error("spi driven before run");

  property p_cfg_hold;
    o_startup_done && !i_cfg_wr && !i_cfg_revert |=> $stable(cfg_now);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");

  property p_cfg_write;
    o_startup_done && i_cfg_wr |=> cfg_now == $past(i_cfg_data);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_flash;
    o_flash_probe_req && i_flash_probe_done |=> o_startup_done && (o_flash_present ==
      ($past(i_flash_detect) && $past(i_flash_size_kbit) >= `BSS_FLASH_MIN_KBIT));
  endproperty
  a_flash: assert property (p_flash) else $error("flash probe result wrong");

  property p_tx_level;
    tx_seen_reg && tx_en_reg && !i_txrdy_cfg_wr |=> o_gpio05 ==
      (((|$past(i_txq_bytes)) && ($past(i_txq_bytes) >= tx_thr_reg)) ^ tx_low_reg);
  endproperty
  a_tx_level: assert property (p_tx_level) else $error("tx pending level wrong");

  property p_tx_oe;
    tx_seen_reg |-> o_gpio05_oe == tx_en_reg;
  endproperty
  a_tx_oe: assert property (p_tx_oe) else $error("tx pending enable wrong");

  property p_speed;
    $rose(i_odo_speed) |-> ##3 o_speed_pulse;
  endproperty
  a_speed: assert property (p_speed) else $error("speed pulse missing");

  c_probe: cover property (o_flash_probe_req && i_flash_probe_done);
  c_cfg: cover property (o_startup_done && i_cfg_wr);
  c_tx: cover property (o_gpio05_oe && o_gpio05);
endmodule

bind bss_top bss_top_sva u_sva (.*);

`default_nettype wire

// ---- bss_flash_model.sv ----
`default_nettype none

module bss_flash_model (
  input  wire logic        i_clk,
  input  wire logic        i_probe_req,
  input  wire logic [9:0]  i_delay,
  input  wire logic        i_present,
  input  wire logic [15:0] i_size,
  output logic             o_done,
  output logic             o_detect,
  output logic [15:0]      o_size
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cnt = 10'h000;
  initial begin
    o_done = 1'h0;
    o_detect = 1'h0;
    o_size = 16'h0000;
  end
  // answer lines churn outside the answer cycle; delay zero never answers
  always @(negedge i_clk) begin
    o_done <= 1'h0;
    o_detect <= ~o_detect;
    o_size <= ~o_size;
    cnt <= i_probe_req ? cnt + 10'h001 : 10'h000;
    if (i_probe_req && i_delay != 10'h000 && cnt == i_delay) begin
      o_done <= 1'h1;
      o_detect <= i_present;
      o_size <= i_size;
    end
  end
endmodule

`default_nettype wire

// ---- testbench.sv ----
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_srst, i_reset_n, i_sensor_variant, i_timing_variant, i_cfg_wr, i_cfg_save;
  logic i_boot_strap_port_sel0, i_boot_strap_port_sel0_drv, i_boot_strap_port_sel1;
  logic i_boot_strap_port_sel1_drv, i_boot_strap_nav_sel0, i_boot_strap_nav_sel0_drv;
  logic i_cfg_revert, i_backup_present, i_flash_probe_done, i_flash_detect, i_spi_mosi;
  logic i_spi_miso, i_spi_sck, i_spi_ss_n, i_core_mosi, i_core_sck, i_core_miso, i_core_miso_oe;
  logic i_core_rate_sel_n, i_core_temp_sel_n, i_txrdy_cfg_wr, i_txrdy_en, i_txrdy_active_low;
  logic i_antenna_present_low, i_ant_cfg_wr, i_antenna_power_off_pin_en, i_antenna_power_off, i_gpio8;
  logic i_gpio17, i_wheel_forward_dir, i_odo_speed, i_ext_event_in, i_event_wake_mode;
  logic i_power_save, o_sys_reset, o_startup_done, o_strap_ss_fault, o_cfg_port_sel0;
  logic o_cfg_port_sel1, o_cfg_nav_sel0, o_flash_probe_req, o_flash_present, o_spi_mosi;
  logic o_spi_mosi_oe, o_spi_miso, o_spi_miso_oe, o_spi_sck, o_spi_sck_oe, o_core_ss_n;
  logic o_rate_sensor_select_n, o_temp_sensor_select_n, o_core_mosi, o_core_miso, o_core_sck;
  logic o_gpio05, o_gpio05_oe, o_gpio13, o_gpio13_oe, o_gpio22, o_gpio22_oe, o_antenna_present;
  logic o_antenna_short_flag, o_antenna_supply_on, o_wheel_forward, o_speed_pulse;
  logic o_time_mark, o_wake_req, fl_present;
  logic [2:0]  i_cfg_data;
  logic [15:0] i_flash_size_kbit, fl_size;
  logic [12:0] i_txrdy_thresh, i_txq_bytes;
  logic [9:0]  fl_delay;
  wire  [2:0]  cfg = {o_cfg_nav_sel0, o_cfg_port_sel1, o_cfg_port_sel0};
  int          failures, checks, sp_cnt, tm_cnt, wk_cnt;
  // bytes, threshold, active low, expected pin level
  logic [12:0] tq[6] = '{13'h0003, 13'h0004, 13'h1FFF, 13'h0000, 13'h0001, 13'h0000};
  logic [12:0] tt[6] = '{13'h0004, 13'h0004, 13'h0004, 13'h0004, 13'h0000, 13'h0000};
  logic        tl[6] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
  logic        tp[6] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1};

  bss_top dut (.*);
  bss_flash_model flash (.i_clk(i_clk), .i_probe_req(o_flash_probe_req), .i_delay(fl_delay),
    .i_present(fl_present), .i_size(fl_size), .o_done(i_flash_probe_done),
    .o_detect(i_flash_detect), .o_size(i_flash_size_kbit));

  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    sp_cnt += int'(o_speed_pulse === 1'h1);
    tm_cnt += int'(o_time_mark === 1'h1);
    wk_cnt += int'(o_wake_req === 1'h1);
  end
  task automatic tick(input int k);
    repeat (k) @(negedge i_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
    tick(1);
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic boot(input logic pin, input logic ssn, input int dly, input logic [15:0] sz);
    int k;
    i_spi_ss_n = ssn;
    fl_delay = 10'(dly);
    fl_size = sz;
    if (pin) i_reset_n = 1'h0;
    else i_srst = 1'h1;
    tick(5);
    if (pin) chk("sys_reset", 16'(o_sys_reset), 16'h0001);
    i_reset_n = 1'h1;
    i_srst = 1'h0;
    for (k = 0; k < 600 && o_startup_done !== 1'h1; k++) tick(1);
    i_spi_ss_n = 1'h1;
    tick(2);
    chk("startup", 16'(o_startup_done), 16'h0001);
  endtask
  initial begin
    #60000;
    failures++;
    stop_test();
  end

  initial begin
    {i_sensor_variant, i_timing_variant, i_cfg_wr, i_cfg_save, i_boot_strap_port_sel0,
     i_boot_strap_port_sel1, i_boot_strap_port_sel1_drv, i_boot_strap_nav_sel0, i_cfg_revert,
     i_backup_present, i_spi_mosi, i_spi_miso, i_spi_sck, i_core_mosi, i_core_sck, i_core_miso,
     i_core_miso_oe, i_txrdy_cfg_wr, i_txrdy_en, i_txrdy_active_low, i_ant_cfg_wr,
     i_antenna_power_off_pin_en, i_antenna_power_off, i_gpio17, i_wheel_forward_dir, i_odo_speed,
     i_ext_event_in, i_event_wake_mode, i_power_save} = '0;
    {i_srst, i_reset_n, i_boot_strap_port_sel0_drv, i_boot_strap_nav_sel0_drv, i_spi_ss_n,
     i_antenna_present_low, i_gpio8, i_core_rate_sel_n, i_core_temp_sel_n, fl_present} = '1;
    {i_cfg_data, i_txrdy_thresh, i_txq_bytes} = '0;
    boot(1'h0, 1'h1, 5, 16'h0400);
    chk("cfg", 16'(cfg), 16'h0002);
    chk("flash", 16'(o_flash_present), 16'h0001);
    chk("ss_fault", 16'(o_strap_ss_fault), 16'h0000);
    {i_spi_mosi, i_spi_miso, i_spi_sck, i_boot_strap_port_sel0, i_core_miso_oe} = 5'h1F;
    tick(8);
    chk("slave", 16'({o_core_mosi, o_core_sck, o_core_ss_n, o_spi_miso_oe}), 16'h000F);
    chk("cfg_spi", 16'(cfg), 16'h0002);
    i_backup_present = 1'h1;
    i_cfg_data = 3'h5;
    pulse(i_cfg_wr);
    chk("cfg_wr", 16'(cfg), 16'h0005);
    pulse(i_cfg_revert);
    chk("cfg_revert", 16'(cfg), 16'h0002);
    pulse(i_cfg_wr);
    pulse(i_cfg_save);
    i_boot_strap_port_sel0 = 1'h0;
    boot(1'h1, 1'h1, 7, 16'h03FF);
    chk("cfg_backup", 16'(cfg), 16'h0005);
    chk("flash_small", 16'(o_flash_present), 16'h0000);
    i_backup_present = 1'h0;
    tick(1);
    // select low at start-up, silent flash
    boot(1'h0, 1'h0, 0, 16'h0400);
    chk("cfg_strap", 16'(cfg), 16'h0002);
    chk("ss_fault", 16'(o_strap_ss_fault), 16'h0001);
    chk("no_flash", 16'(o_flash_present), 16'h0000);
    chk("txrdy_off", 16'(o_gpio05_oe), 16'h0000);
    for (int j = 0; j < 6; j++) begin
      {i_txrdy_en, i_txrdy_active_low, i_txrdy_thresh} = {1'h1, tl[j], tt[j]};
      pulse(i_txrdy_cfg_wr);
      i_txq_bytes = tq[j];
      tick(1);
      chk("txrdy_oe", 16'(o_gpio05_oe), 16'h0001);
      chk("txrdy", 16'(o_gpio05), 16'(tp[j]));
    end
    chk("antenna_power_off_oe", 16'(o_gpio22_oe), 16'h0000);
    {i_antenna_power_off_pin_en, i_antenna_power_off, i_antenna_present_low} = 3'h6;
    pulse(i_ant_cfg_wr);
    tick(3);
    chk("antenna_power_off_on", 16'({o_gpio22_oe, o_gpio22}), 16'h0003);
    chk("ant_present", 16'(o_antenna_present), 16'h0001);
    {i_wheel_forward_dir, i_odo_speed, i_ext_event_in} = 3'h7;
    tick(5);
    chk("forward", 16'(o_wheel_forward), 16'h0001);
    chk("speed", 16'(sp_cnt), 16'h0001);
    chk("mark", 16'(tm_cnt), 16'h0001);
    {i_odo_speed, i_ext_event_in, i_event_wake_mode, i_power_save} = 4'h3;
    tick(4);
    i_ext_event_in = 1'h1;
    tick(5);
    chk("wake", 16'({tm_cnt[3:0], wk_cnt[3:0]}), 16'h0011);
    i_timing_variant = 1'h1;
    boot(1'h0, 1'h1, 5, 16'h0400);
    chk("ant_pins", 16'({o_gpio13, o_gpio13_oe, o_gpio22_oe}), 16'h0006);
    {i_antenna_power_off_pin_en, i_antenna_power_off, i_gpio8, i_gpio17, i_antenna_present_low} = 5'h13;
    pulse(i_ant_cfg_wr);
    tick(3);
    chk("ant_timing", 16'({o_antenna_supply_on, o_antenna_present, o_antenna_short_flag}),
        16'h0007);
    pulse(i_cfg_revert);
    chk("supply_revert", 16'(o_antenna_supply_on), 16'h0000);
    {i_timing_variant, i_sensor_variant} = 2'h1;
    boot(1'h0, 1'h1, 5, 16'h0400);
    chk("master_oe", 16'({o_spi_sck_oe, o_spi_mosi_oe, o_spi_miso_oe}), 16'h0006);
    {i_core_rate_sel_n, i_core_mosi, i_core_sck} = 3'h3;
    tick(1);
    chk("selects", 16'({o_rate_sensor_select_n, o_temp_sensor_select_n}), 16'h0001);
    chk("spi_out", 16'({o_spi_mosi, o_spi_sck, o_core_miso}), 16'h0007);
    stop_test();
  end
endmodule

`default_nettype wire
